//--- include/pwm_stage_pkg.sv
// Register map, field positions and reset values of the PWM output stage
// Function
// - Pin inverted when channel inversion bit set; bit 1 channel 1, bit 0 channel 0.
// - Disabled channels still pass the inverter, holding their inactive level.
// - Fault condition is the trip input or a debug event.
// - During fault, channels with trip-low bit set are forced low.
// - Fault forcing comes before inversion, so inverted forced channel reads high.
// - Pass-through channels keep generating only as debug counter behaviour allows.
// - Module interrupt from trip when enable bit 16, generator when bit 0.
// - Trip raw status latches on detection and holds until software clears.
// - Generator status bits mirror generator interrupt, cleared only at generator.
// - Writing 1 to status-clear bit 16 clears latched trip; 0 does nothing.
// - Summary bit 0 reads 1 while generator asserts interrupt and enable bit 0 is set; read-only.
// - Raw status shows sources regardless of their enable bits.
// - Trip level register bit 0 shows current trip input level.
// - Compare A bit 4: next zero, or first zero after global request.
// - Compare B bit 5 behaves like bit 4 for comparator B.
// - Period bit 3: next zero, or first zero after global request.
// - Debug bit 2 clear halts counter at zero in debug; set always runs.
// - Mode bit 1: count down and reload, or count up then down.
// - Enable bit 0 clear disables generator; set runs it.
// - Generator gives two independent outputs or a complementary pair.
// - Compare match enables: A up bit 2, A down 3, B up 4, B down 5.
// - Period match bit 1 and zero bit 0 enables; any combination allowed.
// - Global update request applies queued updates at next zero, then self-clears.
// - Disabled channel signal replaced by zero before inversion.
package pwm_stage_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  // --------------------------------------------------------------------------
  // Offsets
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_MASTER_CTL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_ENABLE = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_TRIP_OUT = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_MOD_IRQ_EN = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_MOD_RAW = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_MOD_ISC = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_TRIP_LEVEL = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_GEN_CTL = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_GEN_IRQ_EN = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_GEN_RAW = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_GEN_ISC = 12'h04c;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h054;
  localparam logic [ADDR_W-1:0] OFF_CMP_A = 12'h058;
  localparam logic [ADDR_W-1:0] OFF_CMP_B = 12'h05c;
  localparam logic [ADDR_W-1:0] OFF_PAIR_CTL = 12'h068;
  // --------------------------------------------------------------------------
  // Fields
  // --------------------------------------------------------------------------
  localparam int GLOBAL_UPDATE_REQUEST = 0;
  localparam int CH0 = 0;
  localparam int CH1 = 1;
  localparam int TRIP_IRQ_BIT = 16;
  localparam int GENERATOR_IRQ_BIT = 0;
  localparam int TRIP_LEVEL_BIT = 0;
  localparam int GEN_ENABLE = 0;
  localparam int GEN_UPDOWN = 1;
  localparam int GEN_DEBUG_RUN = 2;
  localparam int PERIOD_UPDATE_MODE = 3;
  localparam int COMPARE_A_UPDATE_MODE = 4;
  localparam int COMPARE_B_UPDATE_MODE = 5;
  localparam int GEN_CTL_W = 6;
  localparam int IRQ_COUNTER_AT_ZERO = 0;
  localparam int IRQ_COUNTER_AT_PERIOD = 1;
  localparam int IRQ_CMP_A_UP = 2;
  localparam int IRQ_CMP_A_DOWN = 3;
  localparam int IRQ_CMP_B_UP = 4;
  localparam int IRQ_CMP_B_DOWN = 5;
  localparam int GEN_IRQ_W = 6;
  localparam int PAIR_MODE = 0;
  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [1:0] RST_CH2 = 2'h0;
  localparam logic [GEN_CTL_W-1:0] RST_GEN_CTL = 6'h00;
  localparam logic [GEN_IRQ_W-1:0] RST_GEN_IRQ = 6'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
endpackage : pwm_stage_pkg

//--- src/pwm_stage.sv
// PWM generator control, counter, interrupt summary and pin output stage
module pwm_stage #(
  parameter int CW = pwm_stage_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [pwm_stage_pkg::ADDR_W-1:0] addr,
  input wire logic [pwm_stage_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pwm_stage_pkg::DATA_W-1:0] rdata,
  input wire logic trip_in,
  input wire logic debug_in,
  output logic wave_out_0,
  output logic wave_out_1,
  output logic irq
);
  import pwm_stage_pkg::*;

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Trip input synchroniser
  // --------------------------------------------------------------------------
  logic trip_meta;
  logic trip_sync;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_meta <= 1'b0;
      trip_sync <= 1'b0;
    end else begin
      trip_meta <= trip_in;
      trip_sync <= trip_meta;
    end
  end

  // Debug comes from logic on this clock, so no synchroniser
  logic fault_cond;
  assign fault_cond = trip_sync | debug_in;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  logic [1:0] output_enable;
  logic [1:0] output_polarity_ctl;
  logic [1:0] trip_output_ctl;
  logic irq_en_trip;
  logic irq_en_gen;
  logic [GEN_CTL_W-1:0] generator_control;
  logic [GEN_IRQ_W-1:0] generator_irq_enable;
  logic pair_mode;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] cmp_a_reg;
  logic [CW-1:0] cmp_b_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_enable <= RST_CH2;
      output_polarity_ctl <= RST_CH2;
      trip_output_ctl <= RST_CH2;
      irq_en_trip <= 1'b0;
      irq_en_gen <= 1'b0;
      generator_control <= RST_GEN_CTL;
      generator_irq_enable <= RST_GEN_IRQ;
      pair_mode <= 1'b0;
      period_reg <= RST_CNT;
      cmp_a_reg <= RST_CNT;
      cmp_b_reg <= RST_CNT;
    end else if (wr) begin
      case (addr)
        OFF_OUTPUT_ENABLE: output_enable <= wdata[1:0];
        OFF_POLARITY: output_polarity_ctl <= wdata[1:0];
        OFF_TRIP_OUT: trip_output_ctl <= wdata[1:0];
        OFF_MOD_IRQ_EN: begin
          irq_en_trip <= wdata[TRIP_IRQ_BIT];
          irq_en_gen <= wdata[GENERATOR_IRQ_BIT];
        end
        OFF_GEN_CTL: generator_control <= wdata[GEN_CTL_W-1:0];
        OFF_GEN_IRQ_EN: generator_irq_enable <= wdata[GEN_IRQ_W-1:0];
        OFF_PAIR_CTL: pair_mode <= wdata[PAIR_MODE];
        OFF_PERIOD: period_reg <= wdata[CW-1:0];
        OFF_CMP_A: cmp_a_reg <= wdata[CW-1:0];
        OFF_CMP_B: cmp_b_reg <= wdata[CW-1:0];
        default: begin
        end
      endcase
    end
  end

  logic gen_en;
  logic updown;
  logic debug_run;
  assign gen_en = generator_control[GEN_ENABLE];
  assign updown = generator_control[GEN_UPDOWN];
  assign debug_run = generator_control[GEN_DEBUG_RUN];

  // --------------------------------------------------------------------------
  // Counter and update shadows
  // --------------------------------------------------------------------------
  logic [CW-1:0] cnt;
  logic dir_up;
  logic [CW-1:0] act_period;
  logic [CW-1:0] act_cmp_a;
  logic [CW-1:0] act_cmp_b;
  logic update_req;
  logic at_zero;
  logic halt;
  logic apply_period;
  logic [CW-1:0] next_period;
  // Halt only once zero is reached, so a debug stop never truncates a cycle
  assign at_zero = gen_en && (cnt == RST_CNT);
  assign halt = debug_in && !debug_run && at_zero;
  assign apply_period = at_zero && (!generator_control[PERIOD_UPDATE_MODE] || update_req);
  assign next_period = apply_period ? period_reg : act_period;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      update_req <= 1'b0;
    end else if (wr && addr == OFF_MASTER_CTL && wdata[GLOBAL_UPDATE_REQUEST]) begin
      update_req <= 1'b1;
    end else if (at_zero) begin
      update_req <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_period <= RST_CNT;
      act_cmp_a <= RST_CNT;
      act_cmp_b <= RST_CNT;
    end else begin
      act_period <= next_period;
      if (at_zero && (!generator_control[COMPARE_A_UPDATE_MODE] || update_req)) begin
        act_cmp_a <= cmp_a_reg;
      end
      if (at_zero && (!generator_control[COMPARE_B_UPDATE_MODE] || update_req)) begin
        act_cmp_b <= cmp_b_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= RST_CNT;
      dir_up <= 1'b1;
    end else if (!gen_en) begin
      cnt <= RST_CNT;
      dir_up <= 1'b1;
    end else if (halt) begin
      cnt <= cnt;
    end else if (!updown) begin
      dir_up <= 1'b0;
      cnt <= at_zero ? next_period : cnt - 1'b1;
    end else if (at_zero) begin
      dir_up <= 1'b1;
      cnt <= (next_period == RST_CNT) ? RST_CNT : cnt + 1'b1;
    end else if (dir_up && cnt >= act_period) begin
      dir_up <= 1'b0;
      cnt <= cnt - 1'b1;
    end else begin
      cnt <= dir_up ? cnt + 1'b1 : cnt - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Generator events and status
  // --------------------------------------------------------------------------
  logic going_up;
  logic [GEN_IRQ_W-1:0] gen_ev;
  logic [GEN_IRQ_W-1:0] gen_raw;
  logic gen_irq;
  assign going_up = updown && dir_up;
  // Events fire once per step; a halted counter raises nothing more
  always_comb begin
    gen_ev = '0;
    if (gen_en && !halt) begin
      gen_ev[IRQ_COUNTER_AT_ZERO] = at_zero;
      gen_ev[IRQ_COUNTER_AT_PERIOD] = (cnt == act_period);
      gen_ev[IRQ_CMP_A_UP] = (cnt == act_cmp_a) && going_up;
      gen_ev[IRQ_CMP_A_DOWN] = (cnt == act_cmp_a) && !going_up;
      gen_ev[IRQ_CMP_B_UP] = (cnt == act_cmp_b) && going_up;
      gen_ev[IRQ_CMP_B_DOWN] = (cnt == act_cmp_b) && !going_up;
    end
  end

  // A new event beats a same-cycle write-one-to-clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gen_raw <= RST_GEN_IRQ;
    end else if (wr && addr == OFF_GEN_ISC) begin
      gen_raw <= (gen_raw & ~wdata[GEN_IRQ_W-1:0]) | gen_ev;
    end else begin
      gen_raw <= gen_raw | gen_ev;
    end
  end

  assign gen_irq = |(gen_raw & generator_irq_enable);

  // --------------------------------------------------------------------------
  // Module interrupt summary
  // --------------------------------------------------------------------------
  logic trip_latched;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_latched <= 1'b0;
    end else if (trip_sync) begin
      trip_latched <= 1'b1;
    end else if (wr && addr == OFF_MOD_ISC && wdata[TRIP_IRQ_BIT]) begin
      trip_latched <= 1'b0;
    end
  end

  logic mod_isc_trip;
  logic mod_isc_gen;
  assign mod_isc_trip = trip_latched && irq_en_trip;
  assign mod_isc_gen = gen_irq && irq_en_gen;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= mod_isc_trip || mod_isc_gen;
    end
  end

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  logic [1:0] wave_gen;
  logic [1:0] wave_gated;
  logic [1:0] wave_tripped;
  logic [1:0] wave_pin;
  // Complementary pair has no dead-band delay here; that stage lives elsewhere
  assign wave_gen[CH0] = gen_en && (cnt < act_cmp_a);
  assign wave_gen[CH1] = pair_mode ? (gen_en && !wave_gen[CH0]) : (gen_en && (cnt < act_cmp_b));
  assign wave_gated = wave_gen & output_enable;
  assign wave_tripped = fault_cond ? (wave_gated & ~trip_output_ctl) : wave_gated;
  assign wave_pin = wave_tripped ^ output_polarity_ctl;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_out_0 <= 1'b0;
      wave_out_1 <= 1'b0;
    end else begin
      wave_out_0 <= wave_pin[CH0];
      wave_out_1 <= wave_pin[CH1];
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = RST_RDATA;
    case (addr)
      OFF_MASTER_CTL: next_rdata[GLOBAL_UPDATE_REQUEST] = update_req;
      OFF_OUTPUT_ENABLE: next_rdata[1:0] = output_enable;
      OFF_POLARITY: next_rdata[1:0] = output_polarity_ctl;
      OFF_TRIP_OUT: next_rdata[1:0] = trip_output_ctl;
      OFF_MOD_IRQ_EN: begin
        next_rdata[TRIP_IRQ_BIT] = irq_en_trip;
        next_rdata[GENERATOR_IRQ_BIT] = irq_en_gen;
      end
      OFF_MOD_RAW: begin
        next_rdata[TRIP_IRQ_BIT] = trip_latched;
        next_rdata[GENERATOR_IRQ_BIT] = gen_irq;
      end
      OFF_MOD_ISC: begin
        next_rdata[TRIP_IRQ_BIT] = mod_isc_trip;
        next_rdata[GENERATOR_IRQ_BIT] = mod_isc_gen;
      end
      OFF_TRIP_LEVEL: next_rdata[TRIP_LEVEL_BIT] = trip_sync;
      OFF_GEN_CTL: next_rdata[GEN_CTL_W-1:0] = generator_control;
      OFF_GEN_IRQ_EN: next_rdata[GEN_IRQ_W-1:0] = generator_irq_enable;
      OFF_GEN_RAW: next_rdata[GEN_IRQ_W-1:0] = gen_raw;
      OFF_GEN_ISC: next_rdata[GEN_IRQ_W-1:0] = gen_raw & generator_irq_enable;
      OFF_PERIOD: next_rdata[CW-1:0] = period_reg;
      OFF_COUNT: next_rdata[CW-1:0] = cnt;
      OFF_CMP_A: next_rdata[CW-1:0] = cmp_a_reg;
      OFF_CMP_B: next_rdata[CW-1:0] = cmp_b_reg;
      OFF_PAIR_CTL: next_rdata[PAIR_MODE] = pair_mode;
      default: next_rdata = RST_RDATA;
    endcase
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= RST_RDATA;
    end else begin
      rdata <= rd ? next_rdata : RST_RDATA;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  invert_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    output_polarity_ctl[CH0] && !wave_tripped[CH0] |=> wave_out_0)
    else $error("inverted idle channel 0 not high");
  disabled_ch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !output_enable[CH1] |=> wave_out_1 == $past(output_polarity_ctl[CH1]))
    else $error("disabled channel 1 not at inactive level");
  trip_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_cond && trip_output_ctl[CH0] |=> wave_out_0 == $past(output_polarity_ctl[CH0]))
    else $error("trip did not force channel 0 low before inversion");
  trip_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trip_latched && !(wr && addr == OFF_MOD_ISC && wdata[TRIP_IRQ_BIT]) |=> trip_latched)
    else $error("trip status dropped without clear");
  trip_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr && addr == OFF_MOD_ISC && wdata[TRIP_IRQ_BIT] && !trip_sync |=> !trip_latched)
    else $error("trip status not cleared by write of one");
  irq_summary_a: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_en_trip && trip_latched |=> irq)
    else $error("enabled trip did not raise interrupt");
  update_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
    update_req && at_zero && !wr |=> !update_req)
    else $error("global update request not self-cleared at zero");
  gen_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !gen_en |=> cnt == RST_CNT)
    else $error("disabled generator counter not at zero");
  debug_halt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    halt ##1 debug_in && !debug_run && gen_en |-> $stable(cnt))
    else $error("counter moved while halted in debug");
  down_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
    gen_en && !updown && at_zero && !halt |=> cnt == $past(next_period))
    else $error("count-down did not reload period at zero");
  trip_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == OFF_TRIP_LEVEL |=> rdata[TRIP_LEVEL_BIT] == $past(trip_sync))
    else $error("trip level read mismatch");
  raw_gen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == OFF_MOD_RAW |=> rdata[GENERATOR_IRQ_BIT] == $past(gen_irq))
    else $error("raw generator bit does not mirror generator interrupt");
  raw_trip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == OFF_MOD_RAW |=> rdata[TRIP_IRQ_BIT] == $past(trip_latched))
    else $error("raw trip bit masked or lost");
  summary_gen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == OFF_MOD_ISC |=> rdata[GENERATOR_IRQ_BIT] == $past(mod_isc_gen))
    else $error("summary generator bit mismatch");
  trip_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trip_sync |=> trip_latched)
    else $error("trip level not latched");
  debug_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    debug_in && trip_output_ctl[CH1] |=> wave_out_1 == $past(output_polarity_ctl[CH1]))
    else $error("debug event did not force channel 1");
  period_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    generator_control[PERIOD_UPDATE_MODE] && !update_req |=> $stable(act_period))
    else $error("period applied without update request");
  cmp_a_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    generator_control[COMPARE_A_UPDATE_MODE] && !update_req |=> $stable(act_cmp_a))
    else $error("compare A applied without update request");
  cmp_b_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    generator_control[COMPARE_B_UPDATE_MODE] && !update_req |=> $stable(act_cmp_b))
    else $error("compare B applied without update request");
  irq_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !mod_isc_trip && !mod_isc_gen |=> !irq)
    else $error("interrupt raised with no enabled source");
  gen_enable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (gen_ev & generator_irq_enable) != '0 && !wr |=> gen_irq)
    else $error("enabled generator event did not raise interrupt");
endmodule : pwm_stage

//--- bench/power_stage_model.sv
// Behavioural bridge leg pair driven by the two pin outputs
module power_stage_model (
  input wire logic mclk,
  input wire logic leg_0,
  input wire logic leg_1,
  output int toggles,
  output int overlaps
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_tog = 0;
  int n_ovl = 0;
  logic last_0 = 1'b0;
  assign toggles = n_tog;
  assign overlaps = n_ovl;
  // Counts only; equal legs would short a real bridge, so the bench judges it
  always @(posedge mclk) begin
    if (leg_0 !== last_0) n_tog++;
    if (leg_0 === leg_1) n_ovl++;
    last_0 <= leg_0;
  end
endmodule : power_stage_model

//--- bench/pwm_output_stage_and_gen_control_test.sv
// Self-checking bench for the PWM output stage and generator control
module pwm_output_stage_and_gen_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_stage_pkg::*;
  logic mclk, arst_n, wr, rd, trip_in, debug_in, wave_out_0, wave_out_1, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, mx;
  int failures = 0;
  int num_checks = 0;
  int toggles, overlaps, t0, o0;
  pwm_stage u_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trip_in(trip_in), .debug_in(debug_in), .wave_out_0(wave_out_0),
    .wave_out_1(wave_out_1), .irq(irq));
  power_stage_model u_load (.mclk(mclk), .leg_0(wave_out_0), .leg_1(wave_out_1),
    .toggles(toggles), .overlaps(overlaps));
  // ------------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------------
  task automatic finish_test;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk_val(v, exp);
  endtask : chk_reg
  // Waits are bounded; a pin that never settles ends the run
  task automatic chk_pins(input logic [1:0] exp, input int bound);
    int k;
    k = 0;
    #1;
    while ({wave_out_1, wave_out_0} !== exp && k < bound) begin
      @(posedge mclk);
      #1 k++;
    end
    chk_val({30'h0, wave_out_1, wave_out_0}, {30'h0, exp});
    if ({wave_out_1, wave_out_0} !== exp) finish_test();
  endtask : chk_pins
  task automatic pins_hold(input logic [1:0] exp, input int n);
    repeat (n) begin
      chk_pins(exp, 0);
      @(posedge mclk);
    end
  endtask : pins_hold
  task automatic chk_irq(input logic exp, input int bound);
    int k;
    k = 0;
    #1;
    while (irq !== exp && k < bound) begin
      @(posedge mclk);
      #1 k++;
    end
    chk_val({31'h0, irq}, {31'h0, exp});
    if (irq !== exp) finish_test();
  endtask : chk_irq
  // Stride of three cycles is coprime with the counter cycles used here
  task automatic count_max(input int n, output logic [31:0] m);
    logic [31:0] v;
    m = 32'h0;
    repeat (n) begin
      rd_reg(OFF_COUNT, v);
      if (v > m) m = v;
      @(posedge mclk);
    end
  endtask : count_max
  // ------------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------------
  task automatic t_regs;
    chk_reg(OFF_POLARITY, 32'h0);
    chk_reg(OFF_TRIP_OUT, 32'h0);
    chk_reg(OFF_MOD_IRQ_EN, 32'h0);
    chk_reg(OFF_MOD_ISC, 32'h0);
    chk_reg(OFF_GEN_IRQ_EN, 32'h0);
    wr_reg(OFF_TRIP_LEVEL, 32'h1);
    chk_reg(OFF_TRIP_LEVEL, 32'h0);
    wr_reg(OFF_GEN_CTL, 32'hffff_ffff);
    chk_reg(OFF_GEN_CTL, 32'h3f);
    wr_reg(OFF_GEN_CTL, 32'h0);
    wr_reg(12'h0f0, 32'h1234_5678);
    chk_reg(12'h0f0, 32'h0);
    $display("register map test done");
  endtask : t_regs
  task automatic t_polarity;
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFF_POLARITY, 32'(i));
      chk_pins(2'(i), 4);
    end
    wr_reg(OFF_POLARITY, 32'h0);
    $display("polarity test done");
  endtask : t_polarity
  task automatic t_fault;
    wr_reg(OFF_PERIOD, 32'h4);
    wr_reg(OFF_CMP_A, 32'hffff);
    wr_reg(OFF_CMP_B, 32'hffff);
    wr_reg(OFF_OUTPUT_ENABLE, 32'h3);
    wr_reg(OFF_GEN_CTL, 32'h1);
    chk_pins(2'b11, 12);
    wr_reg(OFF_TRIP_OUT, 32'h1);
    trip_in <= 1'b1;
    chk_pins(2'b10, 6);
    wr_reg(OFF_POLARITY, 32'h1);
    chk_pins(2'b11, 4);
    wr_reg(OFF_POLARITY, 32'h0);
    wr_reg(OFF_TRIP_OUT, 32'h2);
    chk_pins(2'b01, 4);
    @(posedge mclk);
    trip_in <= 1'b0;
    chk_pins(2'b11, 6);
    @(posedge mclk);
    debug_in <= 1'b1;
    chk_pins(2'b01, 4);
    @(posedge mclk);
    debug_in <= 1'b0;
    wr_reg(OFF_TRIP_OUT, 32'h0);
    $display("fault forcing test done");
  endtask : t_fault
  task automatic t_trip_irq;
    wr_reg(OFF_MOD_ISC, 32'h1_0000);
    chk_reg(OFF_MOD_RAW, 32'h0);
    @(posedge mclk);
    trip_in <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_reg(OFF_TRIP_LEVEL, 32'h1);
    chk_reg(OFF_MOD_RAW, 32'h1_0000);
    chk_reg(OFF_MOD_ISC, 32'h0);
    chk_irq(1'b0, 0);
    wr_reg(OFF_MOD_IRQ_EN, 32'h1_0000);
    chk_irq(1'b1, 4);
    @(posedge mclk);
    trip_in <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_reg(OFF_TRIP_LEVEL, 32'h0);
    wr_reg(OFF_MOD_ISC, 32'h0);
    chk_reg(OFF_MOD_ISC, 32'h1_0000);
    wr_reg(OFF_MOD_ISC, 32'h1_0000);
    chk_reg(OFF_MOD_RAW, 32'h0);
    chk_irq(1'b0, 4);
    wr_reg(OFF_MOD_IRQ_EN, 32'h0);
    $display("trip interrupt test done");
  endtask : t_trip_irq
  task automatic t_gen_irq;
    wr_reg(OFF_MOD_IRQ_EN, 32'h1);
    wr_reg(OFF_GEN_IRQ_EN, 32'h3);
    wr_reg(OFF_GEN_ISC, 32'h3f);
    repeat (12) @(posedge mclk);
    chk_reg(OFF_GEN_RAW, 32'h3);
    chk_reg(OFF_MOD_RAW, 32'h1);
    wr_reg(OFF_MOD_ISC, 32'h1);
    chk_reg(OFF_MOD_ISC, 32'h1);
    chk_irq(1'b1, 4);
    wr_reg(OFF_GEN_CTL, 32'h0);
    wr_reg(OFF_GEN_ISC, 32'h3f);
    chk_reg(OFF_MOD_RAW, 32'h0);
    chk_irq(1'b0, 4);
    repeat (10) @(posedge mclk);
    chk_reg(OFF_GEN_RAW, 32'h0);
    $display("generator interrupt test done");
  endtask : t_gen_irq
  task automatic t_modes;
    wr_reg(OFF_CMP_A, 32'h2);
    wr_reg(OFF_CMP_B, 32'h1);
    wr_reg(OFF_GEN_IRQ_EN, 32'h3c);
    wr_reg(OFF_GEN_CTL, 32'h3);
    wr_reg(OFF_GEN_ISC, 32'h3f);
    repeat (20) @(posedge mclk);
    chk_reg(OFF_GEN_RAW, 32'h3f);
    chk_reg(OFF_GEN_ISC, 32'h3c);
    count_max(12, mx);
    chk_val(mx, 32'h4);
    wr_reg(OFF_GEN_CTL, 32'h1);
    wr_reg(OFF_GEN_ISC, 32'h3f);
    repeat (20) @(posedge mclk);
    chk_reg(OFF_GEN_RAW, 32'h2b);
    chk_reg(OFF_GEN_ISC, 32'h28);
    count_max(12, mx);
    chk_val(mx, 32'h4);
    wr_reg(OFF_GEN_IRQ_EN, 32'h0);
    $display("count mode test done");
  endtask : t_modes
  task automatic t_sync;
    wr_reg(OFF_CMP_A, 32'hffff);
    wr_reg(OFF_CMP_B, 32'hffff);
    chk_pins(2'b11, 12);
    wr_reg(OFF_GEN_CTL, 32'h39);
    wr_reg(OFF_PERIOD, 32'h9);
    wr_reg(OFF_CMP_A, 32'h0);
    wr_reg(OFF_CMP_B, 32'h0);
    count_max(12, mx);
    chk_val(mx, 32'h4);
    pins_hold(2'b11, 10);
    wr_reg(OFF_MASTER_CTL, 32'h1);
    chk_pins(2'b00, 20);
    count_max(12, mx);
    chk_val(mx, 32'h9);
    chk_reg(OFF_MASTER_CTL, 32'h0);
    $display("synchronous update test done");
  endtask : t_sync
  task automatic t_pair_debug;
    wr_reg(OFF_GEN_CTL, 32'h1);
    wr_reg(OFF_CMP_A, 32'h2);
    wr_reg(OFF_PAIR_CTL, 32'h1);
    repeat (20) @(posedge mclk);
    t0 = toggles;
    o0 = overlaps;
    repeat (30) @(posedge mclk);
    chk_val(32'(overlaps - o0), 32'h0);
    chk_val({31'h0, toggles > t0}, 32'h1);
    debug_in <= 1'b1;
    repeat (12) @(posedge mclk);
    count_max(4, mx);
    chk_val(mx, 32'h0);
    wr_reg(OFF_GEN_CTL, 32'h5);
    count_max(6, mx);
    chk_val(mx, 32'h9);
    debug_in <= 1'b0;
    $display("pair and debug test done");
  endtask : t_pair_debug
  // ------------------------------------------------------------------------
  // Clock, reset and sequence
  // ------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    arst_n = 1'b0;
    {wr, rd, trip_in, debug_in} = 4'h0;
    addr = 12'h0;
    wdata = 32'h0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_polarity();
    t_fault();
    t_trip_irq();
    t_gen_irq();
    t_modes();
    t_sync();
    t_pair_debug();
    finish_test();
  end
endmodule : pwm_output_stage_and_gen_control_test
